// file: hw/xcvr_mgmt_cfg.svh
// Purpose: constants of the reconfiguration management port
// Assumes: byte addresses on a 7-bit management address
// Notes:   definitions only
`ifndef XCVR_MGMT_CFG_SVH
`define XCVR_MGMT_CFG_SVH

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define CFG_CLK_PERIOD_NS  100
`define CFG_OC_STEP_NS     400
`define CFG_OC_STEP_CYCLES ((`CFG_OC_STEP_NS + `CFG_CLK_PERIOD_NS - 1) / `CFG_CLK_PERIOD_NS)
`define CFG_OP_TIME_NS     800
`define CFG_OP_CYCLES      ((`CFG_OP_TIME_NS + `CFG_CLK_PERIOD_NS - 1) / `CFG_CLK_PERIOD_NS)

// ----------------------------------------------------------------------------
// feature windows (first byte address of each)
// ----------------------------------------------------------------------------
`define CFG_WIN_PMA_BASE   7'h08
`define CFG_WIN_EYE_BASE   7'h10
`define CFG_WIN_DFE_BASE   7'h18
`define CFG_WIN_AEQ_BASE   7'h28
`define CFG_WIN_ATX_BASE   7'h30
`define CFG_WIN_STR_BASE   7'h38
`define CFG_WIN_PLL_BASE   7'h40
`define CFG_WIN_LAST_OFS   3'h4
`define CFG_CTRL_OFS       3'h2

// ----------------------------------------------------------------------------
// control and status word fields
// ----------------------------------------------------------------------------
`define CFG_TRIG_WR_BIT    0
`define CFG_TRIG_RD_BIT    1
`define CFG_BUSY_BIT       8
`define CFG_ERR_BIT        9

`endif

// file: hw/xcvr_mgmt_pkg.sv
// Purpose: types of the reconfiguration management port
// Assumes: nothing beyond the cfg header
// Notes:   state codes are gray along the calibration path
package xcvr_mgmt_pkg;

  // --------------------------------------------------------------------------
  // calibration sequencer states
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    OC_INIT  = 2'b00,
    OC_RUN   = 2'b01,
    OC_LOAD  = 2'b11,
    OC_READY = 2'b10
  } oc_state_t;

  // --------------------------------------------------------------------------
  // feature windows
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    WIN_NONE = 3'h0,
    WIN_PMA  = 3'h1,
    WIN_EYE  = 3'h2,
    WIN_DFE  = 3'h3,
    WIN_AEQ  = 3'h4,
    WIN_ATX  = 3'h5,
    WIN_STR  = 3'h6,
    WIN_PLL  = 3'h7
  } win_t;

endpackage : xcvr_mgmt_pkg

// file: hw/mgmt_reg_mem.sv
// Purpose: word store behind the feature windows
// Assumes: one write and one read port, same clock
// Notes:   read data come out of a register, one cycle after the address
`timescale 1ns/100ps
`default_nettype none

module mgmt_reg_mem #(
  parameter int AW = 7,
  parameter int DW = 32
) (
  // clock and reset
  input  wire logic          clk_sys,
  input  wire logic          reset,
  // write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  // read port
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);

  typedef struct packed {
    logic [(1<<AW)-1:0][DW-1:0] mem;
    logic [DW-1:0]              rd;
  } mem_st_t;

  mem_st_t r_reg;
  mem_st_t r_next;

  // an empty address or data width leaves nothing to store
  if (AW < 1 || DW < 1) begin : g_bad_param
    $error("unsupported memory shape");
  end

  // write first in the array, read the old word: no bypass needed here
  always_comb begin
    r_next = r_reg;
    if (wr_en) begin
      r_next.mem[wr_addr] = wr_data;
    end
    r_next.rd = r_reg.mem[rd_addr];
  end

  // storage clears on reset so reads never show stale contents
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign rd_data = r_reg.rd;

endmodule : mgmt_reg_mem

`default_nettype wire

// file: hw/xcvr_reconfig_mgmt_port.sv
// Purpose: management register port and power-up offset cancellation
// Assumes: master on clk_sys; comparator input from the analog side
// Notes:   reads answer with a fixed two-cycle latency
`timescale 1ns/100ps
`default_nettype none
`include "xcvr_mgmt_cfg.svh"

module xcvr_reconfig_mgmt_port
  import xcvr_mgmt_pkg::*;
#(
  parameter int NUM_CH         = 4,
  parameter int OFS_W          = 6,
  parameter int OC_STEP_CYCLES = `CFG_OC_STEP_CYCLES,
  parameter int OP_CYCLES      = `CFG_OP_CYCLES
) (
  // clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      reset,
  // management port
  input  wire logic [6:0]                mgmt_address,
  input  wire logic [31:0]               mgmt_writedata,
  input  wire logic                      mgmt_write,
  input  wire logic                      mgmt_read,
  output logic      [31:0]               mgmt_readdata,
  output logic                           mgmt_readdatavalid,
  // status
  output logic                           reconfig_busy,
  output logic                           rx_buf_unavail,
  output logic                           oc_done,
  // offset cancellation toward the receivers
  input  wire logic                      oc_cmp_in,
  output logic                           oc_load,
  output logic [$clog2(NUM_CH+1)-1:0]    oc_channel,
  output logic [OFS_W-1:0]               oc_value
);

  localparam int CH_W   = $clog2(NUM_CH + 1);
  localparam int STEP_W = $clog2(OC_STEP_CYCLES + 1);
  localparam int OP_W   = $clog2(OP_CYCLES + 1);
  localparam logic [CH_W-1:0]   CH_LAST   = CH_W'(NUM_CH - 1);
  localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(OC_STEP_CYCLES - 1);
  localparam logic [OP_W-1:0]   OP_LAST   = OP_W'(OP_CYCLES - 1);
  localparam logic [OFS_W-1:0]  OFS_MAX   = '1;

  // --------------------------------------------------------------------------
  // parameter checks
  // --------------------------------------------------------------------------
  // the comparator needs two cycles through its synchroniser, so a step
  // shorter than three cycles would judge the previous offset
  if (NUM_CH < 1 || OC_STEP_CYCLES < 3 || OP_CYCLES < 1 || OFS_W < 1) begin : g_bad_param
    $error("unsupported parameter set");
  end

  // --------------------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------------------
  // upper four address bits pick the eight-byte slot of a window
  function automatic logic in_win(input logic [6:0] a, input logic [6:0] base);
    return a[6:3] == base[6:3];
  endfunction : in_win

  // windows start on eight-byte boundaries, with a gap at 7'h20; only the first five bytes of each are live
  function automatic win_t win_of(input logic [6:0] a);
    win_t w;
    w = WIN_NONE;
    if (a[2:0] <= `CFG_WIN_LAST_OFS) begin
      if      (in_win(a, `CFG_WIN_PMA_BASE)) w = WIN_PMA;
      else if (in_win(a, `CFG_WIN_EYE_BASE)) w = WIN_EYE;
      else if (in_win(a, `CFG_WIN_DFE_BASE)) w = WIN_DFE;
      else if (in_win(a, `CFG_WIN_AEQ_BASE)) w = WIN_AEQ;
      else if (in_win(a, `CFG_WIN_ATX_BASE)) w = WIN_ATX;
      else if (in_win(a, `CFG_WIN_STR_BASE)) w = WIN_STR;
      else if (in_win(a, `CFG_WIN_PLL_BASE)) w = WIN_PLL;
    end
    return w;
  endfunction : win_of

  // the control and status word sits at the same byte of every window
  function automatic logic is_ctrl(input logic [6:0] a);
    return (win_of(a) != WIN_NONE) && (a[2:0] == `CFG_CTRL_OFS);
  endfunction : is_ctrl

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  typedef struct packed {
    oc_state_t         state;
    logic [STEP_W-1:0] step_cnt;
    logic [CH_W-1:0]   ch;
    logic [OFS_W-1:0]  ofs;
    logic [OP_W-1:0]   op_cnt;
    logic              err;
    logic              busy;
    logic              unavail;
    logic              load;
    logic              done;
    logic              cmp_meta;
    logic              cmp_sync;
    logic              rd_p1;
    logic [6:0]        rd_addr_p1;
    logic [31:0]       rdata;
    logic              rvalid;
  } port_st_t;

  port_st_t    r_reg;
  port_st_t    r_next;
  logic        mem_wr_en;
  logic [31:0] mem_rd_data;
  logic        step_en;
  logic        trig;

  // --------------------------------------------------------------------------
  // window storage
  // --------------------------------------------------------------------------
  // control words are built from live state, so they are never stored
  assign mem_wr_en = mgmt_write && (win_of(mgmt_address) != WIN_NONE)
                     && !is_ctrl(mgmt_address);

  mgmt_reg_mem #(
    .AW (7),
    .DW (32)
  ) mgmt_reg_mem_inst (
    .clk_sys (clk_sys),
    .reset   (reset),
    .wr_en   (mem_wr_en),
    .wr_addr (mgmt_address),
    .wr_data (mgmt_writedata),
    .rd_addr (mgmt_address),
    .rd_data (mem_rd_data)
  );

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  // step pulse from the divider paces the offset search
  assign step_en = (r_reg.step_cnt == STEP_LAST);
  assign trig    = mgmt_write && is_ctrl(mgmt_address)
                   && (mgmt_writedata[`CFG_TRIG_WR_BIT] || mgmt_writedata[`CFG_TRIG_RD_BIT]);

  always_comb begin
    r_next      = r_reg;
    r_next.load = 1'b0;
    // comparator pin crosses in; only the second stage is looked at
    r_next.cmp_meta = oc_cmp_in;
    r_next.cmp_sync = r_reg.cmp_meta;

    // offset cancellation sequencer
    case (r_reg.state)
      OC_INIT: begin
        // starts on its own once reset drops
        r_next.state    = OC_RUN;
        r_next.ch       = '0;
        r_next.ofs      = '0;
        r_next.step_cnt = '0;
        r_next.busy     = 1'b1;
        r_next.unavail  = 1'b1;
      end
      OC_RUN: begin
        r_next.step_cnt = step_en ? '0 : r_reg.step_cnt + 1'b1;
        if (step_en) begin
          // stop once the comparator flips or the trim range is spent
          if (r_reg.cmp_sync || r_reg.ofs == OFS_MAX) begin
            r_next.state = OC_LOAD;
            r_next.load  = 1'b1; // pulse while channel and value still stand
          end else begin
            r_next.ofs = r_reg.ofs + 1'b1;
          end
        end
      end
      OC_LOAD: begin
        r_next.step_cnt = '0;
        if (r_reg.ch == CH_LAST) begin
          // last channel trimmed: buffers freed, never run again
          r_next.state   = OC_READY;
          r_next.done    = 1'b1;
          r_next.busy    = 1'b0;
          r_next.unavail = 1'b0;
        end else begin
          r_next.state = OC_RUN;
        end
      end
      OC_READY: begin
        // an operation holds busy for its whole length
        if (r_reg.busy) begin
          if (r_reg.op_cnt == '0) begin
            r_next.busy = 1'b0;
          end else begin
            r_next.op_cnt = r_reg.op_cnt - 1'b1;
          end
        end
      end
      default: begin
        r_next.state = OC_INIT;
      end
    endcase

    // channel advance is held back to here so the load shows the trimmed one
    if (r_reg.state == OC_LOAD && r_reg.ch != CH_LAST) begin
      r_next.ch  = r_reg.ch + 1'b1;
      r_next.ofs = '0;
    end

    // operation triggers: refused while anything runs, flagged as error
    if (trig) begin
      if (r_reg.state == OC_READY && !r_reg.busy) begin
        r_next.busy   = 1'b1;
        r_next.op_cnt = OP_LAST;
        r_next.err    = 1'b0;
      end else begin
        r_next.err = 1'b1;
      end
    end

    // read pipeline: address taken, then memory word, then output
    r_next.rd_p1      = mgmt_read;
    r_next.rd_addr_p1 = mgmt_address;
    r_next.rvalid     = r_reg.rd_p1;
    if (!r_reg.rd_p1) begin
      r_next.rdata = r_reg.rdata;
    end else if (win_of(r_reg.rd_addr_p1) == WIN_NONE) begin
      r_next.rdata = 32'h0000_0000; // unmapped reads answer zero
    end else if (is_ctrl(r_reg.rd_addr_p1)) begin
      r_next.rdata                = 32'h0000_0000;
      r_next.rdata[`CFG_BUSY_BIT] = r_reg.busy;
      r_next.rdata[`CFG_ERR_BIT]  = r_reg.err;
    end else begin
      r_next.rdata = mem_rd_data;
    end
  end

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  // synchronous reset holds everything for as long as it is high
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      r_reg         <= '0;
      r_reg.state   <= OC_INIT;
      r_reg.busy    <= 1'b1;
      r_reg.unavail <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs all straight from the state register
  assign mgmt_readdata      = r_reg.rdata;
  assign mgmt_readdatavalid = r_reg.rvalid;
  assign reconfig_busy      = r_reg.busy;
  assign rx_buf_unavail     = r_reg.unavail;
  assign oc_done            = r_reg.done;
  assign oc_load            = r_reg.load;
  assign oc_channel         = r_reg.ch;
  assign oc_value           = r_reg.ofs;

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  chk_reset_hold: assert property (@(posedge clk_sys)
    reset |=> (r_reg.state == OC_INIT) && reconfig_busy && !mgmt_readdatavalid)
    else $error("reset did not hold the block");

  chk_read_latency: assert property (@(posedge clk_sys) disable iff (reset)
    mgmt_read |-> ##2 mgmt_readdatavalid)
    else $error("read not answered two cycles later");

  chk_unmapped_zero: assert property (@(posedge clk_sys) disable iff (reset)
    (mgmt_read && win_of(mgmt_address) == WIN_NONE) |-> ##2 (mgmt_readdata == 32'h0000_0000))
    else $error("unmapped read returned data");

  chk_write_readback: assert property (@(posedge clk_sys) disable iff (reset)
    (mem_wr_en && !mgmt_read) ##1 (mgmt_read && !mgmt_write
      && mgmt_address == $past(mgmt_address))
    |-> ##2 (mgmt_readdata == $past(mgmt_writedata, 3)))
    else $error("written word not read back");

  chk_oc_buf_busy: assert property (@(posedge clk_sys) disable iff (reset)
    (r_reg.state != OC_READY) |-> (rx_buf_unavail && reconfig_busy && !oc_done))
    else $error("buffers free during calibration");

  chk_oc_once: assert property (@(posedge clk_sys) disable iff (reset)
    (r_reg.state == OC_READY) |=> (r_reg.state == OC_READY) && oc_done && !rx_buf_unavail)
    else $error("calibration ran again");

  chk_load_pulse: assert property (@(posedge clk_sys) disable iff (reset)
    oc_load |=> !oc_load ##1 (!oc_done || oc_channel == CH_LAST))
    else $error("trim load not a single pulse");

  chk_trig_busy: assert property (@(posedge clk_sys) disable iff (reset)
    (trig && r_reg.state == OC_READY && !reconfig_busy) |=> reconfig_busy && !r_reg.err)
    else $error("accepted trigger did not raise busy");

  chk_trig_refused: assert property (@(posedge clk_sys) disable iff (reset)
    (trig && reconfig_busy) |=> r_reg.err)
    else $error("trigger during busy not flagged");

endmodule : xcvr_reconfig_mgmt_port

`default_nettype wire

// file: testbench/mgmt_master.sv
// Purpose: bus master model driving the management port
// Assumes: requests launched 1 ns after a rising edge of clk_sys
// Notes:   released lines show the inverse of the last value
`timescale 1ns/100ps
`default_nettype none

module mgmt_master (
  // clock
  input  wire logic        clk_sys,
  // management port toward the block
  output var  logic [6:0]  mgmt_address,
  output var  logic [31:0] mgmt_writedata,
  output var  logic        mgmt_write,
  output var  logic        mgmt_read,
  input  wire logic [31:0] mgmt_readdata,
  input  wire logic        mgmt_readdatavalid
);
  // ---------------------------------------------------------------------------
  // idle levels
  // ---------------------------------------------------------------------------
  initial begin
    mgmt_address   = 7'h7f;
    mgmt_writedata = 32'h0000_0000;
    mgmt_write     = 1'b0;
    mgmt_read      = 1'b0;
  end

  // ---------------------------------------------------------------------------
  // bus cycles
  // ---------------------------------------------------------------------------
  // one-cycle write strobe, byte address held until the taking edge
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    #1;
    mgmt_address   = a;
    mgmt_writedata = d;
    mgmt_write     = 1'b1;
    @(posedge clk_sys);
    #1;
    mgmt_write     = 1'b0;
    mgmt_address   = ~a;   // no stale value on released lines
    mgmt_writedata = ~d;
  endtask : wr

  // one-cycle read strobe; answer taken at the edge that sees valid high
  task automatic rd(input logic [6:0] a, output logic [31:0] d, output int lat);
    @(posedge clk_sys);
    #1;
    mgmt_address = a;
    mgmt_read    = 1'b1;
    @(posedge clk_sys);
    #1;
    mgmt_read    = 1'b0;
    mgmt_address = ~a;
    collect(d, lat);
  endtask : rd

  // answer taken at the edge that sees valid high, eight edges at most
  task automatic collect(output logic [31:0] d, output int lat);
    lat = 99;
    d   = 32'h0000_0000;
    for (int n = 1; n <= 8; n++) begin
      @(posedge clk_sys);
      if (mgmt_readdatavalid === 1'b1) begin
        lat = n;
        d   = mgmt_readdata;
        break;
      end
    end
  endtask : collect

  // write, then a read of the same word on the very next cycle
  task automatic wr_rd(input logic [6:0] a, input logic [31:0] dw,
                       output logic [31:0] d, output int lat);
    @(posedge clk_sys);
    #1;
    mgmt_address   = a;
    mgmt_writedata = dw;
    mgmt_write     = 1'b1;
    @(posedge clk_sys);
    #1;
    mgmt_write     = 1'b0;
    mgmt_writedata = ~dw;
    mgmt_read      = 1'b1;
    @(posedge clk_sys);
    #1;
    mgmt_read      = 1'b0;
    mgmt_address   = ~a;
    collect(d, lat);
  endtask : wr_rd
endmodule : mgmt_master

`default_nettype wire

// file: testbench/test_xcvr_reconfig_mgmt_port.sv
// Purpose: self-checking bench of the management port and power-up trim
// Assumes: comparator trips at a fixed offset per channel
// Notes:   short step and operation counts keep the run brief
`timescale 1ns/100ps
`default_nettype none

module test_xcvr_reconfig_mgmt_port;
  localparam int NCH = 4, STEP_N = 4, OP_N = 8, LIMIT = 20000;
  logic        clk_sys, reset, oc_cmp_in, mgmt_write, mgmt_read, mgmt_readdatavalid;
  logic        reconfig_busy, rx_buf_unavail, oc_done, oc_load;
  logic [6:0]  mgmt_address;
  logic [31:0] mgmt_writedata, mgmt_readdata;
  logic [2:0]  oc_channel;
  logic [5:0]  oc_value;
  int          error_cnt, checked, cyc;
  logic [2:0]  ld_ch[$];
  logic [5:0]  ld_val[$];
  logic [5:0]  trip[NCH] = '{6'h05, 6'h00, 6'h0a, 6'h3f};
  logic [6:0]  bases[7] = '{7'h08, 7'h10, 7'h18, 7'h28, 7'h30, 7'h38, 7'h40};
  logic [6:0]  holes[10] = '{7'h00, 7'h07, 7'h0d, 7'h0f, 7'h1d, 7'h20, 7'h27, 7'h2d,
                             7'h45, 7'h7f};

  // ---------------------------------------------------------------------------
  // block, master and analog side
  // ---------------------------------------------------------------------------
  xcvr_reconfig_mgmt_port #(.NUM_CH(NCH), .OFS_W(6), .OC_STEP_CYCLES(STEP_N),
    .OP_CYCLES(OP_N)) xcvr_reconfig_mgmt_port_inst (.clk_sys(clk_sys), .reset(reset),
    .mgmt_address(mgmt_address), .mgmt_writedata(mgmt_writedata),
    .mgmt_write(mgmt_write), .mgmt_read(mgmt_read), .mgmt_readdata(mgmt_readdata),
    .mgmt_readdatavalid(mgmt_readdatavalid), .reconfig_busy(reconfig_busy),
    .rx_buf_unavail(rx_buf_unavail), .oc_done(oc_done), .oc_cmp_in(oc_cmp_in),
    .oc_load(oc_load), .oc_channel(oc_channel), .oc_value(oc_value));
  mgmt_master mgmt_master_inst (.clk_sys(clk_sys), .mgmt_address(mgmt_address),
    .mgmt_writedata(mgmt_writedata), .mgmt_write(mgmt_write), .mgmt_read(mgmt_read),
    .mgmt_readdata(mgmt_readdata), .mgmt_readdatavalid(mgmt_readdatavalid));

  initial begin
    clk_sys   = 1'b0;
    oc_cmp_in = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // comparator flips once the trim reaches the channel's trip point
  always @(posedge clk_sys) begin
    #1 oc_cmp_in = (oc_channel < NCH) ? (oc_value >= trip[oc_channel]) : 1'b0;
  end

  // ---------------------------------------------------------------------------
  // compare and report
  // ---------------------------------------------------------------------------
  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word

  task automatic chk_bit(input string nm, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit

  task automatic close_out();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out

  // hang guard and trim load recorder
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == LIMIT) begin
      error_cnt++;
      close_out();
    end
    if (reset === 1'b0 && oc_load === 1'b1) begin
      ld_ch.push_back(oc_channel);
      ld_val.push_back(oc_value);
      chk_bit("busy at load", 1'b1, reconfig_busy);
      chk_bit("unavail at load", 1'b1, rx_buf_unavail);
    end
  end

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] pat(input logic [6:0] a);
    return {8'hc3, 1'b0, a, 9'h000, ~a};
  endfunction : pat

  task automatic test_reset();
    chk_bit("busy in reset", 1'b1, reconfig_busy);
    chk_bit("unavail in reset", 1'b1, rx_buf_unavail);
    chk_bit("done in reset", 1'b0, oc_done);
    chk_bit("valid in reset", 1'b0, mgmt_readdatavalid);
    chk_bit("load in reset", 1'b0, oc_load);
  endtask : test_reset

  // every word but the control word of every window, then the gaps; gaps must not alias
  task automatic test_windows();
    logic [6:0]  a;
    logic [31:0] d;
    int          lat;
    foreach (bases[w]) for (int o = 0; o < 5; o++) if (o != 2) begin
      mgmt_master_inst.wr(bases[w] + 7'(o), pat(bases[w] + 7'(o)));
    end
    foreach (holes[i]) mgmt_master_inst.wr(holes[i], 32'hffff_ffff);
    foreach (bases[w]) for (int o = 0; o < 5; o++) if (o != 2) begin
      a = bases[w] + 7'(o);
      mgmt_master_inst.rd(a, d, lat);
      chk_word("window word", pat(a), d);
      chk_word("read latency", 32'h0000_0002, lat);
    end
    foreach (holes[i]) begin
      mgmt_master_inst.rd(holes[i], d, lat);
      chk_word("unmapped word", 32'h0000_0000, d);
    end
  endtask : test_windows

  // a read right behind a write to the same word sees the new value
  task automatic test_write_read();
    logic [31:0] d;
    int          lat;
    mgmt_master_inst.wr_rd(7'h3b, 32'h5a5a_0f0f, d, lat);
    chk_word("read after write", 32'h5a5a_0f0f, d);
    chk_word("read after write latency", 32'h0000_0002, lat);
  endtask : test_write_read

  task automatic test_calib();
    for (int n = 0; n < 3000 && oc_done !== 1'b1; n++) @(posedge clk_sys);
    #1;
    chk_bit("oc done", 1'b1, oc_done);
    chk_bit("busy after trim", 1'b0, reconfig_busy);
    chk_bit("unavail after trim", 1'b0, rx_buf_unavail);
    chk_word("load count", NCH, ld_ch.size());
    for (int i = 0; i < ld_ch.size() && i < NCH; i++) begin
      chk_word("load channel", i, ld_ch[i]);
      chk_bit("trim near trip", 1'b1, ld_val[i] >= trip[i] &&
              int'(ld_val[i]) <= int'(trip[i]) + 1);
    end
  endtask : test_calib

  // wait for busy to drop, sampled just after each edge
  task automatic wait_idle();
    for (int n = 0; n < 50; n++) begin
      @(posedge clk_sys);
      #1;
      if (reconfig_busy === 1'b0) break;
    end
  endtask : wait_idle

  // accepted trigger, refused trigger while busy, status word, error clear
  task automatic test_trigger();
    logic [31:0] d;
    int          lat;
    longint      t0;
    mgmt_master_inst.wr(7'h0a, 32'h0000_0001);
    t0 = $time;
    chk_bit("busy after trigger", 1'b1, reconfig_busy);
    mgmt_master_inst.wr(7'h2a, 32'h0000_0002);
    mgmt_master_inst.rd(7'h32, d, lat);
    chk_word("status while busy", 32'h0000_0300, d);
    wait_idle();
    chk_word("busy length", OP_N, 32'(($time - t0) / 100));
    mgmt_master_inst.rd(7'h1a, d, lat);
    chk_word("status error kept", 32'h0000_0200, d);
    mgmt_master_inst.wr(7'h42, 32'h0000_0002);
    chk_bit("busy after read trigger", 1'b1, reconfig_busy);
    mgmt_master_inst.rd(7'h0a, d, lat);
    chk_word("status error cleared", 32'h0000_0100, d);
    wait_idle();
    chk_bit("busy falls", 1'b0, reconfig_busy);
  endtask : test_trigger

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    error_cnt = 0;
    checked   = 0;
    cyc       = 0;
    reset     = 1'b1; // held from time zero with the rest of the link
    repeat (2) @(posedge clk_sys);
    #1;
    test_reset();
    reset = 1'b0;
    test_windows();
    test_write_read();
    test_calib();
    test_trigger();
    chk_word("loads after run", NCH, ld_ch.size());
    close_out();
  end
endmodule : test_xcvr_reconfig_mgmt_port

`default_nettype wire
